// ==== common/cq_pkg.sv ====
// Shared constants, beat layouts and state encodings for the completer request stream.
`default_nettype none

package cq_pkg;

  // --------------------------------------------------------------------------
  // Bus geometry
  // --------------------------------------------------------------------------
  localparam int MAX_BUS_W   = 256;
  localparam int DWORD_W     = 32;
  localparam int BYTE_W      = 8;
  localparam int KEEP_W      = MAX_BUS_W / DWORD_W;
  localparam int SIDEBAND_W  = 85;
  localparam int DW_CNT_W    = 4;
  localparam int BYTE_EN_LSB = 8;
  localparam int BYTE_EN_W   = 32;
  localparam int BUS_W_64    = 64;
  localparam int BUS_W_128   = 128;

  // --------------------------------------------------------------------------
  // Credit and buffering
  // --------------------------------------------------------------------------
  localparam int                   CREDIT_W    = 6;
  localparam logic [CREDIT_W-1:0]  CREDIT_MAX  = 6'h20;
  localparam logic [CREDIT_W-1:0]  CREDIT_ZERO = 6'h00;
  localparam logic [CREDIT_W-1:0]  CREDIT_ONE  = 6'h01;
  localparam int                   FIFO_DEPTH  = 32;
  localparam int                   PKT_CNT_W   = 6;
  localparam logic [PKT_CNT_W-1:0] PKT_ZERO    = 6'h00;
  localparam logic [PKT_CNT_W-1:0] PKT_ONE     = 6'h01;
  localparam logic [DW_CNT_W-1:0]  DW_FULL     = 4'h0;

  // --------------------------------------------------------------------------
  // Beat carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [MAX_BUS_W-1:0]  payload;
    logic [SIDEBAND_W-1:0] sideband;
    logic [DW_CNT_W-1:0]   dwords;
    logic                  last;
    logic                  nonposted;
  } link_beat_s;

  typedef struct packed {
    logic [MAX_BUS_W-1:0]  payload;
    logic [SIDEBAND_W-1:0] sideband;
    logic [KEEP_W-1:0]     keep;
    logic                  last;
  } req_beat_s;

  // --------------------------------------------------------------------------
  // Steering states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    IN_IDLE    = 2'b00,
    IN_NP      = 2'b01,
    IN_POSTED  = 2'b10
  } in_state_e;

  typedef enum logic [1:0] {
    OUT_IDLE   = 2'b00,
    OUT_NP     = 2'b01,
    OUT_POSTED = 2'b10
  } out_state_e;

endpackage : cq_pkg

`default_nettype wire

// ==== hdl/cq_beat_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides, used to park non-posted packets.
`timescale 1ns/100ps
`default_nettype none

module cq_beat_fifo
  import cq_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic      [WIDTH-1:0] rd_data
);

  // DEPTH must be a power of two; the extra pointer bit tells full from empty.
  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W:0]              wr_ptr;
    logic [PTR_W:0]              rd_ptr;
  } fifo_state_s;

  fifo_state_s st_reg;
  fifo_state_s st_next;
  logic        full;
  logic        empty;

  assign empty    = (st_reg.wr_ptr == st_reg.rd_ptr);
  assign full     = (st_reg.wr_ptr[PTR_W] != st_reg.rd_ptr[PTR_W]) &&
                    (st_reg.wr_ptr[PTR_W-1:0] == st_reg.rd_ptr[PTR_W-1:0]);
  assign wr_ready = !full;
  assign rd_valid = !empty;
  assign rd_data  = st_reg.mem[st_reg.rd_ptr[PTR_W-1:0]];

  always_comb begin
    st_next = st_reg;
    if (wr_valid && !full) begin
      st_next.mem[st_reg.wr_ptr[PTR_W-1:0]] = wr_data;
      st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
    end
    if (rd_ready && !empty) begin
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : cq_beat_fifo

`default_nettype wire

// ==== hdl/cq_np_credit.sv ====
// Saturating credit counter that gates delivery of non-posted requests.
`timescale 1ns/100ps
`default_nettype none

module cq_np_credit
  import cq_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                srst,
  input  wire logic                clear,
  input  wire logic                request,
  input  wire logic                consume,
  output logic      [CREDIT_W-1:0] count
);

  typedef struct packed {
    logic                req_q;
    logic [CREDIT_W-1:0] count;
  } credit_state_s;

  credit_state_s st_reg;
  credit_state_s st_next;

  assign count = st_reg.count;

  // The request is staged one cycle, so the count visibly lags the pulse.
  always_comb begin
    st_next       = st_reg;
    st_next.req_q = request;
    if (clear) begin
      st_next.req_q = 1'b0;
      st_next.count = CREDIT_ZERO;
    end else if (st_reg.req_q && consume) begin
      st_next.count = st_reg.count;
    end else if (st_reg.req_q) begin
      if (st_reg.count != CREDIT_MAX) begin
        st_next.count = st_reg.count + CREDIT_ONE;
      end
    end else if (consume && (st_reg.count != CREDIT_ZERO)) begin
      st_next.count = st_reg.count - CREDIT_ONE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : cq_np_credit

`default_nettype wire

// ==== hdl/cq_request_stream.sv ====
// Completer request stream output with credit-gated non-posted delivery.
//
// Summary of operation
// - Last-beat flag is raised in the final beat of every packet.
// - A single-beat packet carries the last-beat flag in its only beat.
// - Keep bits mark valid Dwords, contiguous from descriptor start to payload end.
// - Keep is all ones except in a short final beat.
// - Keep lanes beyond the configured bus width are held at zero.
// - Valid is high with meaningful data and stays high throughout a non-posted packet; a posted packet gaps whenever link valid does.
// - A beat moves only when valid and ready are both high.
// - With valid high and ready low, data and valid are held unchanged.
// - Each cycle with the credit request input high adds one credit.
// - Each non-posted packet delivered removes one credit.
// - A non-posted packet starts only while credit is nonzero.
// - Posted packets keep flowing while non-posted delivery waits for credit, until the non-posted FIFO is full and stalls the link.
// - The request input may change in any cycle, regardless of packet boundaries.
// - The credit count is a 6-bit output that saturates at 32.
// - The count output may lag a request pulse by pipeline cycles.
// - Credit clears on user reset and when link-up drops.
// - Bus width is 64, 128 or 256 bits and sizes keep and byte enables.
// - Payload bits above the configured width are driven to zero.
// - The sideband bus is 85 bits, meaningful only while valid is high.
`timescale 1ns/100ps
`default_nettype none

module cq_request_stream
  import cq_pkg::*;
#(
  parameter int BUS_W = MAX_BUS_W
) (
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  input  wire logic                  link_up,
  input  wire logic                  link_beat_valid,
  output logic                       link_beat_ready,
  input  wire link_beat_s            link_beat,
  output logic      [MAX_BUS_W-1:0]  req_stream_payload,
  output logic      [SIDEBAND_W-1:0] req_stream_sideband,
  output logic      [KEEP_W-1:0]     req_stream_dword_keep,
  output logic                       req_stream_last,
  output logic                       req_stream_valid,
  input  wire logic                  req_stream_ready,
  input  wire logic                  nonposted_credit_request,
  output logic      [CREDIT_W-1:0]   nonposted_credit_count
);

  // --------------------------------------------------------------------------
  // Width handling
  // --------------------------------------------------------------------------

  // Any width other than the two narrow ones is treated as the full bus.
  function automatic int legal_width();
    if (BUS_W == BUS_W_64) begin
      return BUS_W_64;
    end
    if (BUS_W == BUS_W_128) begin
      return BUS_W_128;
    end
    return MAX_BUS_W;
  endfunction : legal_width

  // Dword lanes that exist in the configured width.
  function automatic logic [KEEP_W-1:0] bus_lanes();
    logic [KEEP_W-1:0] m;
    m = '0;
    for (int i = 0; i < KEEP_W; i++) begin
      m[i] = (i < (legal_width() / DWORD_W));
    end
    return m;
  endfunction : bus_lanes

  // Contiguous lanes from lane 0 up to n Dwords; zero means the whole bus.
  function automatic logic [KEEP_W-1:0] lanes_up_to(input logic [DW_CNT_W-1:0] n);
    logic [KEEP_W-1:0] m;
    m = '0;
    for (int i = 0; i < KEEP_W; i++) begin
      m[i] = (n == DW_FULL) || (i < int'(n));
    end
    return m & bus_lanes();
  endfunction : lanes_up_to

  // Zeroes payload lanes above the configured width.
  function automatic logic [MAX_BUS_W-1:0] payload_mask(input logic [MAX_BUS_W-1:0] d);
    logic [MAX_BUS_W-1:0] r;
    logic [KEEP_W-1:0]    lanes;
    r     = '0;
    lanes = bus_lanes();
    for (int i = 0; i < KEEP_W; i++) begin
      if (lanes[i]) begin
        r[i*DWORD_W +: DWORD_W] = d[i*DWORD_W +: DWORD_W];
      end
    end
    return r;
  endfunction : payload_mask

  // Zeroes byte enables in the sideband for bytes that the bus lacks.
  function automatic logic [SIDEBAND_W-1:0] sideband_mask(input logic [SIDEBAND_W-1:0] s);
    logic [SIDEBAND_W-1:0] r;
    r = s;
    for (int i = 0; i < BYTE_EN_W; i++) begin
      if (i >= (legal_width() / BYTE_W)) begin
        r[BYTE_EN_LSB + i] = 1'b0;
      end
    end
    return r;
  endfunction : sideband_mask

  // Turns a link beat into an outgoing beat with its qualifiers.
  function automatic req_beat_s shape_beat(input link_beat_s b);
    req_beat_s r;
    r.payload  = payload_mask(b.payload);
    r.sideband = sideband_mask(b.sideband);
    r.last     = b.last;
    if (b.last) begin
      r.keep = lanes_up_to(b.dwords);
    end else begin
      r.keep = bus_lanes();
    end
    return r;
  endfunction : shape_beat

  // --------------------------------------------------------------------------
  // Packet bookkeeping
  // --------------------------------------------------------------------------

  // Complete packets waiting in the FIFO; a push and a pop in one cycle cancel.
  function automatic logic [PKT_CNT_W-1:0] pkt_step(input logic [PKT_CNT_W-1:0] n,
                                                   input logic                 up,
                                                   input logic                 down);
    logic [PKT_CNT_W-1:0] r;
    r = n;
    if (up && !down) begin
      r = n + PKT_ONE;
    end else if (down && !up) begin
      r = n - PKT_ONE;
    end
    return r;
  endfunction : pkt_step

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------

  typedef struct packed {
    in_state_e            in_state;
    out_state_e           out_state;
    logic                 out_valid;
    req_beat_s            out_beat;
    logic [PKT_CNT_W-1:0] np_pkts;
  } stream_state_s;

  stream_state_s         st_reg;
  stream_state_s         st_next;

  logic                  fifo_wr_valid;
  logic                  fifo_wr_ready;
  logic                  fifo_rd_valid;
  logic                  fifo_rd_ready;
  link_beat_s            fifo_rd_data;
  logic [CREDIT_W-1:0]   credit_count;
  logic                  credit_clear;

  logic                  in_np_path;
  logic                  in_p_path;
  logic                  out_take;
  logic                  np_eligible;
  logic                  start_np;
  logic                  start_p;
  logic                  np_flow;
  logic                  p_flow;
  logic                  np_load;
  logic                  p_load;
  logic                  link_take;
  logic                  fifo_push_last;
  logic                  fifo_pop_last;
  logic                  out_idle;

  // --------------------------------------------------------------------------
  // Input steering
  // --------------------------------------------------------------------------

  // Packets are steered whole: the first beat's class decides the path.
  assign in_np_path = (st_reg.in_state == IN_NP) ||
                      ((st_reg.in_state == IN_IDLE) && link_beat.nonposted);
  assign in_p_path  = !in_np_path;

  assign fifo_wr_valid   = link_beat_valid && in_np_path;
  // A full FIFO stalls the link, and with it any posted packet queued behind.
  assign link_beat_ready = in_np_path ? fifo_wr_ready : p_flow;
  assign link_take       = link_beat_valid && link_beat_ready;
  assign fifo_push_last  = fifo_wr_valid && fifo_wr_ready && link_beat.last;

  // --------------------------------------------------------------------------
  // Output arbitration
  // --------------------------------------------------------------------------

  // The output register may load when it is empty or its beat is taken.
  assign out_take = !st_reg.out_valid || req_stream_ready;

  // Only a packet already complete in the FIFO may start, so valid never gaps.
  assign np_eligible = (st_reg.np_pkts != PKT_ZERO) &&
                       (credit_count != CREDIT_ZERO);

  // Packets never interleave: a new one starts only between packets.
  assign out_idle = (st_reg.out_state == OUT_IDLE);
  assign start_np = out_idle && np_eligible && out_take;
  assign start_p  = out_idle && !np_eligible && out_take &&
                    link_beat_valid && in_p_path;

  assign np_flow = start_np || ((st_reg.out_state == OUT_NP) && out_take);
  assign p_flow  = start_p || ((st_reg.out_state == OUT_POSTED) && out_take);

  // The FIFO pops only into the output register, so a pop is always a load.
  assign fifo_rd_ready = np_flow;
  assign np_load       = np_flow && fifo_rd_valid;
  assign p_load        = p_flow && link_beat_valid && in_p_path;
  assign fifo_pop_last = np_load && fifo_rd_data.last;

  // --------------------------------------------------------------------------
  // Credit
  // --------------------------------------------------------------------------

  // Losing the link wipes the credit and any request still in flight.
  assign credit_clear = !link_up;

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------

  always_comb begin
    st_next = st_reg;

    if (out_take) begin
      st_next.out_valid = np_load || p_load;
      if (np_load) begin
        st_next.out_beat = shape_beat(fifo_rd_data);
      end else if (p_load) begin
        st_next.out_beat = shape_beat(link_beat);
      end
    end

    // The output side leaves a packet only after loading its last beat.
    case (st_reg.out_state)
      OUT_IDLE: begin
        if (np_load && !fifo_rd_data.last) begin
          st_next.out_state = OUT_NP;
        end else if (p_load && !link_beat.last) begin
          st_next.out_state = OUT_POSTED;
        end
      end
      OUT_NP: begin
        if (np_load && fifo_rd_data.last) begin
          st_next.out_state = OUT_IDLE;
        end
      end
      OUT_POSTED: begin
        if (p_load && link_beat.last) begin
          st_next.out_state = OUT_IDLE;
        end
      end
      default: begin
        st_next.out_state = OUT_IDLE;
      end
    endcase

    // The input side follows the packet on the link so its class sticks.
    case (st_reg.in_state)
      IN_IDLE: begin
        if (link_take && !link_beat.last) begin
          if (link_beat.nonposted) begin
            st_next.in_state = IN_NP;
          end else begin
            st_next.in_state = IN_POSTED;
          end
        end
      end
      IN_NP, IN_POSTED: begin
        if (link_take && link_beat.last) begin
          st_next.in_state = IN_IDLE;
        end
      end
      default: begin
        st_next.in_state = IN_IDLE;
      end
    endcase

    // Only whole packets count, so a started packet never waits on the link.
    st_next.np_pkts = pkt_step(st_reg.np_pkts, fifo_push_last, fifo_pop_last);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // --------------------------------------------------------------------------
  // Sub-blocks
  // --------------------------------------------------------------------------

  // Non-posted beats park here until a whole packet and a credit are ready.
  cq_beat_fifo #(
    .WIDTH    ($bits(link_beat_s)),
    .DEPTH    (FIFO_DEPTH)
  ) u_np_fifo (
    .core_clk (core_clk),
    .srst     (srst),
    .wr_valid (fifo_wr_valid),
    .wr_ready (fifo_wr_ready),
    .wr_data  (link_beat),
    .rd_valid (fifo_rd_valid),
    .rd_ready (fifo_rd_ready),
    .rd_data  (fifo_rd_data)
  );

  // Credit is taken at packet start, so the count never gates a packet midway.
  cq_np_credit u_np_credit (
    .core_clk (core_clk),
    .srst     (srst),
    .clear    (credit_clear),
    .request  (nonposted_credit_request),
    .consume  (start_np),
    .count    (credit_count)
  );

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------

  assign req_stream_valid       = st_reg.out_valid;
  assign req_stream_payload     = st_reg.out_beat.payload;
  assign req_stream_sideband    = st_reg.out_beat.sideband;
  assign req_stream_dword_keep  = st_reg.out_beat.keep;
  assign req_stream_last        = st_reg.out_beat.last;
  assign nonposted_credit_count = credit_count;

endmodule : cq_request_stream

`default_nettype wire

// ==== tb/cq_request_stream_checker.sv ====
// Concurrent checks on the completer request stream ports.
`timescale 1ns/100ps
`default_nettype none
module cq_request_stream_checker
  import cq_pkg::*;
#(
  parameter int BUS_W = MAX_BUS_W
) (
  input wire logic                  core_clk,
  input wire logic                  srst,
  input wire logic                  link_up,
  input wire logic                  link_beat_valid,
  input wire logic                  link_beat_ready,
  input wire link_beat_s            link_beat,
  input wire logic [MAX_BUS_W-1:0]  req_stream_payload,
  input wire logic [SIDEBAND_W-1:0] req_stream_sideband,
  input wire logic [KEEP_W-1:0]     req_stream_dword_keep,
  input wire logic                  req_stream_last,
  input wire logic                  req_stream_valid,
  input wire logic                  req_stream_ready,
  input wire logic                  nonposted_credit_request,
  input wire logic [CREDIT_W-1:0]   nonposted_credit_count
);
  localparam logic [KEEP_W-1:0] KEEP_FULL = KEEP_W'((1 << (BUS_W / DWORD_W)) - 1);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_stalled;
    req_stream_valid && !req_stream_ready;
  endsequence
  sequence s_mid_beat;
    req_stream_valid && req_stream_ready && !req_stream_last;
  endsequence
  a_stall_hold: assert property (
    s_stalled |=> req_stream_valid && $stable(req_stream_payload) && $stable(req_stream_last)
      && $stable(req_stream_dword_keep) && $stable(req_stream_sideband))
    else $error("stalled beat changed");
  a_pkt_valid: assert property (s_mid_beat |=> req_stream_valid)
    else $error("valid dropped inside a packet");
  a_keep_full: assert property (
    req_stream_valid && !req_stream_last |-> req_stream_dword_keep == KEEP_FULL)
    else $error("keep not full in a middle beat");
  a_keep_contig: assert property (
    req_stream_valid |-> req_stream_dword_keep != '0
      && ((req_stream_dword_keep + 1'b1) & req_stream_dword_keep) == '0)
    else $error("keep not contiguous from lane zero");
  a_upper_zero: assert property (
    (req_stream_payload >> BUS_W) == '0 && (req_stream_dword_keep >> (BUS_W / DWORD_W)) == '0)
    else $error("lanes above bus width not zero");
  a_credit_sat: assert property (nonposted_credit_count <= CREDIT_MAX)
    else $error("credit above limit");
  a_link_clear: assert property (!link_up |=> nonposted_credit_count == CREDIT_ZERO)
    else $error("credit kept with link down");
  a_no_stray_inc: assert property (
    !$past(nonposted_credit_request, 2) |-> nonposted_credit_count <= $past(nonposted_credit_count))
    else $error("credit rose without request");
  a_credit_step: assert property (
    !$past(srst) && $past(link_up) && link_up |->
      nonposted_credit_count == $past(nonposted_credit_count)
      || nonposted_credit_count == $past(nonposted_credit_count) + 1
      || nonposted_credit_count + 1 == $past(nonposted_credit_count))
    else $error("credit moved by more than one");
endmodule : cq_request_stream_checker
bind cq_request_stream cq_request_stream_checker #(.BUS_W(BUS_W)) i_cq_request_stream_checker (
  .core_clk(core_clk), .srst(srst), .link_up(link_up), .link_beat_valid(link_beat_valid),
  .link_beat_ready(link_beat_ready), .link_beat(link_beat), .req_stream_payload(req_stream_payload),
  .req_stream_sideband(req_stream_sideband), .req_stream_dword_keep(req_stream_dword_keep),
  .req_stream_last(req_stream_last), .req_stream_valid(req_stream_valid),
  .req_stream_ready(req_stream_ready), .nonposted_credit_request(nonposted_credit_request),
  .nonposted_credit_count(nonposted_credit_count));
`default_nettype wire

// ==== tb/cq_request_stream_tb.sv ====
// Self-checking bench for the completer request stream.
`timescale 1ns/100ps
`default_nettype none
module cq_request_stream_tb;
  import cq_pkg::*;
  localparam int BUS_W = BUS_W_128;
  localparam int NK    = BUS_W / DWORD_W;
  logic core_clk = 0, srst = 1, link_up = 1, link_beat_valid = 0, stall_en = 1, coin = 0;
  link_beat_s link_beat = '0;
  logic [MAX_BUS_W-1:0] pay;
  logic [SIDEBAND_W-1:0] sb;
  logic [KEEP_W-1:0] keep;
  logic [CREDIT_W-1:0] count;
  logic lbr, last, valid, ready, request;
  int n_mismatch = 0, checks = 0, seed = 32'h575f;
  req_beat_s exp_q[$], pend_q[$], mon_e;
  cq_request_stream #(.BUS_W(BUS_W)) i_cq_request_stream (.core_clk(core_clk), .srst(srst),
    .link_up(link_up), .link_beat_valid(link_beat_valid), .link_beat_ready(lbr),
    .link_beat(link_beat), .req_stream_payload(pay), .req_stream_sideband(sb),
    .req_stream_dword_keep(keep), .req_stream_last(last), .req_stream_valid(valid),
    .req_stream_ready(ready), .nonposted_credit_request(request),
    .nonposted_credit_count(count));
  cq_user_model i_cq_user_model (.core_clk(core_clk), .stall_en(stall_en), .coin(coin),
    .req_stream_ready(ready), .nonposted_credit_request(request));
  always #25 core_clk = ~core_clk;
  always @(negedge core_clk) coin <= 1'($random(seed));
  task automatic check(input string what, input logic [383:0] seen, input logic [383:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // --------------------------------------------------------------------------
  // Link-side driver: one beat per handshake, expectation noted per beat.
  // --------------------------------------------------------------------------
  task automatic send(input logic np, input int beats, input int dw, input logic hold);
    req_beat_s e;
    logic ok;
    int n;
    for (int b = 0; b < beats; b++) begin
      for (int w = 0; w < 8; w++) link_beat.payload[w*32+:32] = $random(seed);
      link_beat.sideband  = SIDEBAND_W'({$random(seed), $random(seed), $random(seed)});
      link_beat.last      = (b == beats - 1);
      link_beat.dwords    = link_beat.last ? DW_CNT_W'(dw) : DW_FULL;
      link_beat.nonposted = np;
      e.payload  = link_beat.payload & {{(MAX_BUS_W-BUS_W){1'b0}}, {BUS_W{1'b1}}};
      e.sideband = link_beat.sideband & ~(SIDEBAND_W'(32'hFFFF) << 24);
      e.keep     = KEEP_W'((1 << ((link_beat.last && dw != 0) ? dw : NK)) - 1);
      e.last     = link_beat.last;
      if (hold) pend_q.push_back(e);
      else exp_q.push_back(e);
      link_beat_valid = 1'b1;
      n = 0;
      do begin
        #24 ok = lbr;
        @(negedge core_clk);
        n++;
      end while (ok !== 1'b1 && n < 2000);
      check("link ready", ok, 1'b1);
    end
    link_beat_valid = 1'b0;
    @(negedge core_clk);
  endtask : send
  task automatic drain;
    int n = 0;
    while ((exp_q.size() > 0 || valid === 1'b1) && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    check("queue empty", exp_q.size(), 0);
  endtask : drain
  task automatic cnt(input logic [CREDIT_W-1:0] exp);
    repeat (4) @(negedge core_clk);
    check("credit count", count, exp);
  endtask : cnt
  always @(negedge core_clk) begin
    #24;
    if (valid === 1'b1 && ready === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected beat", 1, 0);
      else begin
        mon_e = exp_q.pop_front();
        check("beat", {pay, sb, keep, last}, mon_e);
      end
    end
  end
  initial begin
    #(50 * 40000);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (20) @(negedge core_clk);
    srst = 0;
    @(negedge core_clk);
    for (int d = 0; d <= NK; d++) send(0, 1 + d, d, 0);
    drain();
    i_cq_user_model.give_credit(2);
    cnt(2);
    send(1, 2, 1, 0);
    send(1, 1, 0, 0);
    drain();
    cnt(0);
    send(1, 3, 2, 1);
    send(0, 2, 3, 0);
    drain();
    while (pend_q.size() > 0) exp_q.push_back(pend_q.pop_front());
    i_cq_user_model.give_credit(1);
    drain();
    cnt(0);
    for (int p = 0; p < FIFO_DEPTH / 4; p++) send(1, 4, 0, 1);
    link_beat.nonposted = 1'b1;
    link_beat_valid = 1'b1;
    #24 check("fifo full refuses", lbr, 0);
    @(negedge core_clk);
    link_beat_valid = 1'b0;
    while (pend_q.size() > 0) exp_q.push_back(pend_q.pop_front());
    i_cq_user_model.give_credit(FIFO_DEPTH / 4);
    drain();
    cnt(0);
    stall_en = 0;
    fork
      i_cq_user_model.give_credit(6);
      for (int k = 0; k < 3; k++) send(1, 1, k + 1, 0);
    join
    drain();
    cnt(3);
    i_cq_user_model.give_credit(40);
    cnt(CREDIT_MAX);
    link_up = 0;
    @(negedge core_clk);
    link_up = 1;
    cnt(0);
    i_cq_user_model.give_credit(5);
    cnt(5);
    srst = 1;
    repeat (2) @(negedge core_clk);
    srst = 0;
    cnt(0);
    give_verdict();
  end
endmodule : cq_request_stream_tb
`default_nettype wire

// ==== tb/cq_user_model.sv ====
// User logic model: paces the request stream and hands out non-posted credit.
`timescale 1ns/100ps
`default_nettype none
module cq_user_model (
  input  wire logic core_clk,
  input  wire logic stall_en,
  input  wire logic coin,
  output var logic  req_stream_ready,
  output var logic  nonposted_credit_request
);
  initial begin
    req_stream_ready = 1'b1;
    nonposted_credit_request = 1'b0;
  end
  // Ready drops at random while stall_en is high, so that beats must survive a stall.
  always @(negedge core_clk) req_stream_ready <= !(stall_en && coin);
  // No tagged requests leave this model, so tag reuse spacing holds trivially.
  // Consecutive cycles give a held level, a single cycle gives one pulse.
  task automatic give_credit(input int n);
    repeat (n) begin
      @(negedge core_clk);
      nonposted_credit_request <= 1'b1;
    end
    @(negedge core_clk);
    nonposted_credit_request <= 1'b0;
  endtask : give_credit
endmodule : cq_user_model
`default_nettype wire
